// file: verilog/psm_pkg.sv
package psm_pkg;
	// Register byte offsets on the APB bus
	localparam logic [11:0] PSM_OFF_DATA = 12'h000;
	localparam logic [11:0] PSM_OFF_DIR = 12'h004;
	localparam logic [11:0] PSM_OFF_MODE = 12'h008;
	localparam logic [11:0] PSM_OFF_FUNC = 12'h00C;
	// Values after reset
	localparam logic [15:0] PSM_DATA_RST = 16'h0000;
	localparam logic [15:0] PSM_DIR_RST = 16'hFFFF;
	localparam logic [15:0] PSM_MODE_RST = 16'h0000;
	localparam logic [15:0] PSM_FUNC_RST = 16'h0000;
	// Implemented bits of the mode and function registers, then of the data and direction registers
	localparam logic [15:0] PSM_ALT_MASK = 16'h3C07;
	localparam logic [15:0] PSM_FULL_MASK = 16'hFFFF;
	// Field positions
	localparam int PSM_PINS = 16;
	localparam int PSM_TMR_LSB = 10;
	localparam int PSM_TMR_N = 4;
	localparam int PSM_IRQ_LSB = 0;
	localparam int PSM_IRQ_N = 3;
	localparam int PSM_SYNC_STAGES = 2;
endpackage

// file: verilog/psm_sync.sv
`timescale 1ns/1ns
module psm_sync
	import psm_pkg::*;
#(
	parameter int WIDTH = PSM_PINS
) (
	// Clock and reset
	input wire logic pclk,
	input wire logic presetn,
	// Asynchronous in, synchronous out
	input wire logic [WIDTH-1:0] async_in,
	output logic [WIDTH-1:0] sync_out
);
	logic [WIDTH-1:0] meta_q;
	logic [WIDTH-1:0] meta_d;
	logic [WIDTH-1:0] sync_d;

	if (WIDTH < 1) begin : g_bad_width
		$error("psm_sync: WIDTH must be at least 1");
	end

	// First stage feeds only the second stage
	always_comb begin
		meta_d = async_in;
		sync_d = meta_q;
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			meta_q <= '0;
			sync_out <= '0;
		end else begin
			meta_q <= meta_d;
			sync_out <= sync_d;
		end
	end
endmodule

// file: verilog/psm_port6.sv
`timescale 1ns/1ns
// Overview of operation
// RQ1 - The data register reads back the level on each pin, and its written value sets what each output pin drives.
// RQ2 - The data register takes full 16-bit writes and each of its two bytes may also be written alone.
// RQ3 - A direction bit of 0 makes its pin an output and a 1 makes it an input, each pin on its own.
// RQ4 - The direction register is 16 bits wide and each of its two bytes may also be written alone.
// RQ5 - The mode register is 16 bits wide and each of its two bytes may also be written alone.
// RQ6 - Mode bits 10 to 13 leave their pins as port pins at 0 and give them to the timer channels at 1.
// RQ7 - Mode bits 0 to 2 leave their pins as port pins at 0 and route them to the external interrupt inputs at 1.
// RQ8 - Software sets a pin's function bit to 1 before it sets the mode bit, otherwise the pin output is undefined.
// RQ9 - A function bit picks timer input at 0 and timer output at 1, and 0 is not allowed on interrupt pins.
// RQ10 - Mode bits that are not implemented read as zero and ignore writes.
module psm_port6
	import psm_pkg::*;
#(
	parameter int ADDR_W = 12
) (
	// APB slave
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [ADDR_W-1:0] paddr,
	input wire logic [31:0] pwdata,
	input wire logic [3:0] pstrb,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	// Port pins
	input wire logic [PSM_PINS-1:0] pin_in,
	output logic [PSM_PINS-1:0] pin_out,
	output logic [PSM_PINS-1:0] pin_oe,
	// Timer channels
	input wire logic [PSM_TMR_N-1:0] timer2_compare_out,
	output logic [PSM_TMR_N-1:0] timer2_capture_in,
	// External interrupt inputs
	output logic [PSM_IRQ_N-1:0] ext_irq_in
);
	logic [15:0] data_q, data_d;
	logic [15:0] dir_q, dir_d;
	logic [15:0] mode_q, mode_d;
	logic [15:0] func_q, func_d;
	logic [31:0] prdata_d;
	logic pready_d, pslverr_d;
	logic [PSM_PINS-1:0] pin_out_d, pin_oe_d;
	logic [PSM_TMR_N-1:0] cap_d;
	logic [PSM_IRQ_N-1:0] irq_d;
	logic [PSM_PINS-1:0] pin_sync;
	logic sel_data, sel_dir, sel_mode, sel_func, hit, setup, wr;

	if (ADDR_W < 4 || ADDR_W > 32) begin : g_bad_addr_w
		$error("psm_port6: ADDR_W must lie between 4 and 32");
	end

	// Pin levels are asynchronous and must be synchronised before use
	psm_sync #(.WIDTH(PSM_PINS)) u_sync (
		.pclk(pclk),
		.presetn(presetn),
		.async_in(pin_in),
		.sync_out(pin_sync)
	);

	function automatic logic [15:0] merge(input logic [15:0] old, input logic [31:0] wd,
			input logic [3:0] st, input logic [15:0] mask);
		logic [15:0] lanes;
		lanes = {{8{st[1]}}, {8{st[0]}}};
		merge = ((old & ~lanes) | (wd[15:0] & lanes)) & mask;
	endfunction

	always_comb begin
		sel_data = (paddr == ADDR_W'(PSM_OFF_DATA));
		sel_dir = (paddr == ADDR_W'(PSM_OFF_DIR));
		sel_mode = (paddr == ADDR_W'(PSM_OFF_MODE));
		sel_func = (paddr == ADDR_W'(PSM_OFF_FUNC));
		hit = sel_data | sel_dir | sel_mode | sel_func;
		setup = psel & ~penable;
		// Write commits only at the access edge and never on an error
		wr = psel & penable & pready & pwrite & ~pslverr;
	end

	// Register file next values
	always_comb begin
		data_d = data_q;
		dir_d = dir_q;
		mode_d = mode_q;
		func_d = func_q;
		if (wr && sel_data) begin
			data_d = merge(data_q, pwdata, pstrb, PSM_FULL_MASK); // [RQ1] [RQ2]
		end
		if (wr && sel_dir) begin
			dir_d = merge(dir_q, pwdata, pstrb, PSM_FULL_MASK); // [RQ4]
		end
		if (wr && sel_mode) begin
			mode_d = merge(mode_q, pwdata, pstrb, PSM_ALT_MASK); // [RQ5] [RQ10]
		end
		if (wr && sel_func) begin
			func_d = merge(func_q, pwdata, pstrb, PSM_ALT_MASK); // [RQ9]
		end
	end

	// Bus answer: read data is captured in setup so that it stays steady through the access
	always_comb begin
		prdata_d = prdata;
		pready_d = setup;
		pslverr_d = 1'b0;
		if (setup) begin
			pslverr_d = ~hit;
			prdata_d = 32'h0000_0000;
			if (sel_data) begin
				prdata_d[15:0] = pin_sync; // [RQ1]
			end else if (sel_dir) begin
				prdata_d[15:0] = dir_q;
			end else if (sel_mode) begin
				prdata_d[15:0] = mode_q; // [RQ10]
			end else if (sel_func) begin
				prdata_d[15:0] = func_q;
			end
		end
	end

	// Pin steering; a timer pin in alternate mode with function 0 stays undriven as a safe choice
	for (genvar g = 0; g < PSM_PINS; g++) begin : g_pin
		if (g >= PSM_TMR_LSB && g < PSM_TMR_LSB + PSM_TMR_N) begin : g_tmr
			assign pin_out_d[g] = mode_q[g] ? func_q[g] & timer2_compare_out[g-PSM_TMR_LSB] : data_q[g]; // [RQ6]
			assign pin_oe_d[g] = mode_q[g] ? func_q[g] : ~dir_q[g]; // [RQ3] [RQ8] [RQ9]
			assign cap_d[g-PSM_TMR_LSB] = pin_sync[g] & mode_q[g] & ~func_q[g]; // [RQ6] [RQ9]
		end else if (g >= PSM_IRQ_LSB && g < PSM_IRQ_LSB + PSM_IRQ_N) begin : g_irq
			assign pin_out_d[g] = mode_q[g] ? 1'b0 : data_q[g]; // [RQ1]
			assign pin_oe_d[g] = mode_q[g] ? 1'b0 : ~dir_q[g]; // [RQ3] [RQ7]
			assign irq_d[g-PSM_IRQ_LSB] = pin_sync[g] & mode_q[g]; // [RQ7]
		end else begin : g_plain
			assign pin_out_d[g] = data_q[g]; // [RQ1]
			assign pin_oe_d[g] = ~dir_q[g]; // [RQ3]
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			data_q <= PSM_DATA_RST;
			dir_q <= PSM_DIR_RST;
			mode_q <= PSM_MODE_RST;
			func_q <= PSM_FUNC_RST;
			prdata <= 32'h0000_0000;
			pready <= 1'b0;
			pslverr <= 1'b0;
			pin_out <= '0;
			pin_oe <= '0;
			timer2_capture_in <= '0;
			ext_irq_in <= '0;
		end else begin
			data_q <= data_d;
			dir_q <= dir_d;
			mode_q <= mode_d;
			func_q <= func_d;
			prdata <= prdata_d;
			pready <= pready_d;
			pslverr <= pslverr_d;
			pin_out <= pin_out_d;
			pin_oe <= pin_oe_d;
			timer2_capture_in <= cap_d;
			ext_irq_in <= irq_d;
		end
	end

	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);

	AST_DATA_READ: assert property (setup && sel_data && !pwrite |=> // [RQ1]
		prdata == {16'h0000, $past(pin_sync)} && pready)
		else $error("data read did not return pin levels");
	AST_DATA_DRIVE: assert property (1'b1 |=> // [RQ1]
		(pin_out & ~$past(mode_q)) == ($past(data_q) & ~$past(mode_q)))
		else $error("port pin does not drive the data register value");
	AST_DATA_BYTE: assert property (wr && sel_data && pstrb[1:0] == 2'b01 |=> // [RQ2]
		data_q[15:8] == $past(data_q[15:8]) && data_q[7:0] == $past(pwdata[7:0]))
		else $error("low byte write of data register disturbed the other byte");
	AST_DIR_OE: assert property (1'b1 |=> // [RQ3]
		(pin_oe & ~$past(mode_q)) == (~$past(dir_q) & ~$past(mode_q)))
		else $error("output enable does not follow direction");
	AST_DIR_HIGH: assert property (wr && sel_dir && pstrb[1:0] == 2'b10 |=> // [RQ4]
		dir_q[15:8] == $past(pwdata[15:8]) && dir_q[7:0] == $past(dir_q[7:0]))
		else $error("high byte write of direction register wrong");
	AST_MODE_WORD: assert property (wr && sel_mode && pstrb[1:0] == 2'b11 |=> // [RQ5]
		mode_q == ($past(pwdata[15:0]) & PSM_ALT_MASK))
		else $error("mode register word write wrong");
	AST_TMR_OUT: assert property (mode_q[13] && func_q[13] |=> // [RQ6]
		pin_oe[13] && pin_out[13] == $past(timer2_compare_out[3]))
		else $error("timer output not driven on its pin");
	AST_TMR_IN: assert property (mode_q[10] && !func_q[10] |=> // [RQ9]
		!pin_oe[10] && timer2_capture_in[0] == $past(pin_sync[10]))
		else $error("timer input pin not released to the capture input");
	AST_IRQ: assert property (1'b1 |=> // [RQ7]
		ext_irq_in == $past(pin_sync[2:0] & mode_q[2:0]) && (pin_oe[2:0] & $past(mode_q[2:0])) == 3'h0)
		else $error("interrupt routing wrong");
	AST_UNIMPL: assert property ( // [RQ10]
		(mode_q & ~PSM_ALT_MASK) == 16'h0000 && (func_q & ~PSM_ALT_MASK) == 16'h0000)
		else $error("unimplemented mode bits set");
	AST_UNMAPPED: assert property (setup && !hit |=> pslverr && pready)
		else $error("unmapped address not refused");
	AST_READY_PULSE: assert property (pready |=>
		!pready)
		else $error("ready stood longer than one cycle");
	AST_READ_HOLD: assert property (!setup |=>
		$stable(prdata))
		else $error("read data changed outside a setup cycle");
	AST_DIR_READ: assert property (setup && sel_dir && !pwrite |=> // [RQ4]
		prdata == {16'h0000, $past(dir_q)} && !pslverr)
		else $error("direction register read wrong");
	AST_MODE_READ: assert property (setup && sel_mode && !pwrite |=> // [RQ10]
		prdata == {16'h0000, $past(mode_q) & PSM_ALT_MASK})
		else $error("mode register read shows unimplemented bits");
	AST_FUNC_READ: assert property (setup && sel_func && !pwrite |=> // [RQ9]
		prdata == {16'h0000, $past(func_q)} && !pslverr)
		else $error("function register read wrong");
	AST_FUNC_HIGH: assert property (wr && sel_func && pstrb[1:0] == 2'b10 |=> // [RQ9]
		func_q[15:8] == ($past(pwdata[15:8]) & PSM_ALT_MASK[15:8]) && func_q[7:0] == $past(func_q[7:0]))
		else $error("high byte write of function register wrong");
	AST_DATA_WORD: assert property (wr && sel_data && pstrb[1:0] == 2'b11 |=> // [RQ2]
		data_q == $past(pwdata[15:0]))
		else $error("data register word write wrong");
	AST_READ_NO_WRITE: assert property (psel && penable && !pwrite |=>
		$stable(data_q) && $stable(dir_q) && $stable(mode_q) && $stable(func_q))
		else $error("register changed during a read");
endmodule

// file: tb/psm_pad_model.sv
`timescale 1ns/1ns
module psm_pad_model
	import psm_pkg::*;
(
	// Pad side of the port
	input wire logic [PSM_PINS-1:0] pin_out,
	input wire logic [PSM_PINS-1:0] pin_oe,
	// Level from the outside world
	input wire logic [PSM_PINS-1:0] ext_lvl,
	output logic [PSM_PINS-1:0] pin_in
);
	// An undriven pad follows the outside level, never the stale output
	assign pin_in = (pin_oe & pin_out) | (~pin_oe & ext_lvl);
endmodule

// file: tb/testbench.sv
`timescale 1ns/1ns
module testbench
	import psm_pkg::*;
;
	logic pclk = 1'b0;
	logic presetn = 1'b0;
	logic psel = 1'b0;
	logic penable = 1'b0;
	logic pwrite = 1'b0;
	logic [11:0] paddr = 12'h000;
	logic [31:0] pwdata = 32'h0;
	logic [3:0] pstrb = 4'h0;
	logic [31:0] prdata;
	logic pready;
	logic pslverr;
	logic [15:0] pin_in, pin_out, pin_oe;
	logic [15:0] ext_lvl = 16'h0000;
	logic [3:0] tmr = 4'h0;
	logic [3:0] cap;
	logic [2:0] irq;
	logic [31:0] rs = 32'h3F0B;
	logic [16:0] exp_q[$];
	logic [15:0] d, e, x, t;
	int n_fail = 0;
	int n_tests = 0;

	always #50 pclk = ~pclk;

	psm_port6 dut_u (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
		.paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready), .pslverr(pslverr),
		.pin_in(pin_in), .pin_out(pin_out), .pin_oe(pin_oe), .timer2_compare_out(tmr),
		.timer2_capture_in(cap), .ext_irq_in(irq));
	psm_pad_model pad_u (.pin_out(pin_out), .pin_oe(pin_oe), .ext_lvl(ext_lvl), .pin_in(pin_in));

	function automatic logic [15:0] xs();
		rs = rs ^ (rs << 13);
		rs = rs ^ (rs >> 17);
		rs = rs ^ (rs << 5);
		return rs[15:0];
	endfunction

	task automatic chk(input logic [16:0] got, input logic [16:0] want);
		n_tests++;
		if (got !== want) begin
			n_fail++;
			$display("CHECK FAILED at %0t got %h expected %h", $time, got, want);
		end
	endtask

	task automatic final_report();
		$display("comparisons %0d mismatches %0d", n_tests, n_fail);
		if (n_fail == 0 && n_tests > 0) begin
			$display("SIMULATION PASSED");
		end else begin
			$display("SIMULATION FAILED");
		end
		$finish;
	endtask

	// Request held until pready is seen high; no wait count assumed
	task automatic apb(input logic w, input logic [11:0] a, input logic [15:0] dat, input logic [3:0] s);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= w;
		paddr <= a;
		pwdata <= {16'h0000, dat};
		pstrb <= s;
		@(posedge pclk);
		penable <= 1'b1;
		do @(posedge pclk); while (pready !== 1'b1);
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge pclk);
	endtask

	task automatic rd(input logic [11:0] a, input logic [16:0] want);
		exp_q.push_back(want);
		apb(1'b0, a, 16'h0000, 4'h0);
	endtask

	// Pins settle through the synchroniser and output flops
	task automatic settle();
		repeat (4) @(posedge pclk);
	endtask

	always @(posedge pclk) begin
		if (psel && penable && pready && !pwrite) begin
			chk({pslverr, prdata[15:0]}, exp_q.pop_front());
		end
	end

	initial begin
		repeat (3000) @(posedge pclk);
		n_fail++;
		final_report();
	end

	initial begin
		repeat (2) @(posedge pclk);
		presetn <= 1'b1;
		@(posedge pclk);
		rd(PSM_OFF_DIR, {1'b0, PSM_DIR_RST});
		rd(PSM_OFF_MODE, {1'b0, PSM_MODE_RST});
		rd(PSM_OFF_FUNC, {1'b0, PSM_FUNC_RST});
		d = xs();
		e = xs();
		x = xs();
		t = xs();
		apb(1'b1, PSM_OFF_DATA, d, 4'h3);
		apb(1'b1, PSM_OFF_DIR, 16'h0000, 4'h1);
		apb(1'b1, PSM_OFF_DIR, 16'h0000, 4'h2);
		settle();
		chk(pin_oe, 16'hFFFF);
		rd(PSM_OFF_DATA, {1'b0, d});
		apb(1'b1, PSM_OFF_DATA, e, 4'h1);
		ext_lvl <= x;
		apb(1'b1, PSM_OFF_DIR, 16'hFF00, 4'h2);
		settle();
		chk(pin_oe, 16'h00FF);
		rd(PSM_OFF_DATA, {1'b0, x[15:8], e[7:0]});
		// Function bits go first, so the pins never see an undefined output
		apb(1'b1, PSM_OFF_FUNC, 16'hFFFF, 4'h3);
		apb(1'b1, PSM_OFF_MODE, 16'hFFFF, 4'h3);
		tmr <= t[3:0];
		rd(PSM_OFF_MODE, {1'b0, PSM_ALT_MASK});
		rd(PSM_OFF_FUNC, {1'b0, PSM_ALT_MASK});
		settle();
		chk(irq, x[2:0]);
		chk(pin_oe, 16'h3CF8);
		chk(pin_out[13:10], t[3:0]);
		chk(cap, 4'h0);
		apb(1'b1, PSM_OFF_FUNC, 16'h0000, 4'h2);
		settle();
		chk(pin_oe, 16'h00F8);
		chk(cap, x[13:10]);
		apb(1'b1, PSM_OFF_MODE, 16'h0000, 4'h3);
		settle();
		chk(pin_oe, 16'h00FF);
		chk({cap, irq}, 7'h00);
		rd(12'h010, {1'b1, 16'h0000});
		final_report();
	end
endmodule
